// >>> design/tq_regs.vh
// constants for the battery temperature qualification and safety timer block
// assumes a 100 MHz system clock and a word-indexed register port
`ifndef TQ_REGS_VH
`define TQ_REGS_VH

// register indexes
`define TQ_REG_CTRL        4'h0
`define TQ_REG_VREG        4'h1
`define TQ_REG_ICHG        4'h2
`define TQ_REG_BOOST_WIN   4'h3
`define TQ_REG_STATUS      4'h4
`define TQ_REG_TIMER       4'h5

// control register fields
`define TQ_CTRL_CHARGE_ALLOW   0
`define TQ_CTRL_TIMER_EN       1
`define TQ_CTRL_LONG_TIMER     2
`define TQ_CTRL_SLOW_COUNT     3
`define TQ_CTRL_ZONE_LIMIT     4
`define TQ_CTRL_WARM_V_FULL    5
`define TQ_CTRL_WARM_I_LO      6
`define TQ_CTRL_COOL_I_SEL     8
`define TQ_CTRL_COOL_EN        9
`define TQ_CTRL_COOL_V_LOWER   10
`define TQ_CTRL_COOL_T_LO      11
`define TQ_CTRL_WARM_T_LO      13
`define TQ_CTRL_SYS_FLOOR_LO   15
`define TQ_CTRL_BOOST_EN       18
`define TQ_CTRL_WIDTH          19
`define TQ_CTRL_RESET          19'h3_829F

// reset values of the setting registers
`define TQ_VREG_RESET          16'h1070
`define TQ_ICHG_RESET          12'h7BC
`define TQ_BOOST_COLD_RESET    10'h2F8
`define TQ_BOOST_HOT_RESET     10'h0FA

// voltages in mV
`define TQ_WARM_COOL_VMAX      16'h1004
`define TQ_SYS_ABOVE_FLOOR     16'h00B4
`define TQ_SYS_ABOVE_BAT       16'h0032
`define TQ_SYS_FLOOR_BASE      16'h0AF0
`define TQ_SYS_FLOOR_STEP      16'h0064

// thermistor sense thresholds, 10-bit codes, higher code is colder
`define TQ_T1_COLD             10'h2E4
`define TQ_T4_HOT              10'h12C
`define TQ_T2_TABLE            {10'h2A8, 10'h294, 10'h280, 10'h26C}
`define TQ_T3_TABLE            {10'h1B8, 10'h1A4, 10'h190, 10'h17C}

// zone codes
`define TQ_ZONE_NORMAL         3'h0
`define TQ_ZONE_WARM           3'h2
`define TQ_ZONE_COOL           3'h3
`define TQ_ZONE_COLD           3'h5
`define TQ_ZONE_HOT            3'h6

// status codes
`define TQ_CHG_FAULT_TIMER     2'h3
`define TQ_SRC_BOOST           3'h7

// timing
`define TQ_CLK_HZ              100000000
`define TQ_CLK_MHZ             100
`define TQ_INT_PULSE_US        256
`define TQ_SHORT_LIMIT_H       2
`define TQ_LONG_LIMIT_H        16
`define TQ_MID_LIMIT_H         7
`define TQ_SEC_PER_H           3600

`endif

// >>> design/thermal_zone_classify.v
// thermistor sense code to temperature zone classifier
// assumes a sense code already synchronous to clk_sys_i
`timescale 1ns/1ps
`default_nettype none
`include "tq_regs.vh"

module thermal_zone_classify #(
   parameter SENSE_W = 10
) (
   input  wire               clk_sys_i,
   input  wire               nrst_i,
   input  wire               ce_i,
   input  wire [SENSE_W-1:0] thermistor_sense_i,
   input  wire [1:0]         cool_threshold_select_i,
   input  wire [1:0]         warm_threshold_select_i,
   output reg  [2:0]         zone_o
);

   reg [SENSE_W-1:0] t2;
   reg [SENSE_W-1:0] t3;
   reg [2:0]         zone_d;
   reg [39:0]        t2_tab;
   reg [39:0]        t3_tab;

   // lower sense voltage means hotter battery
   always @* begin
      t2_tab = `TQ_T2_TABLE;
      t3_tab = `TQ_T3_TABLE;
      t2 = t2_tab[(3 - cool_threshold_select_i) * 10 +: 10];
      t3 = t3_tab[(3 - warm_threshold_select_i) * 10 +: 10];
      if (thermistor_sense_i >= `TQ_T1_COLD)
         zone_d = `TQ_ZONE_COLD;
      else if (thermistor_sense_i <= `TQ_T4_HOT)
         zone_d = `TQ_ZONE_HOT;
      else if (thermistor_sense_i >= t2)
         zone_d = `TQ_ZONE_COOL;
      else if (thermistor_sense_i <= t3)
         zone_d = `TQ_ZONE_WARM;
      else
         zone_d = `TQ_ZONE_NORMAL;
   end

   always @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i)
         zone_o <= `TQ_ZONE_NORMAL;
      else if (ce_i)
         zone_o <= zone_d;
   end

endmodule
`default_nettype wire

// >>> design/event_pulse_gen.v
// fixed-width active-low pulse on any request
// requests while a pulse runs merge into it
`timescale 1ns/1ps
`default_nettype none

module event_pulse_gen #(
   parameter PULSE_CYCLES = 25600,
   parameter CNT_W        = 15
) (
   input  wire clk_sys_i,
   input  wire nrst_i,
   input  wire ce_i,
   input  wire trig_i,
   output reg  pulse_n_o
);

   reg [CNT_W-1:0] cnt_q;

   always @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cnt_q     <= {CNT_W{1'b0}};
         pulse_n_o <= 1'b1;
      end else if (ce_i) begin
         if (pulse_n_o && trig_i) begin
            cnt_q     <= PULSE_CYCLES[CNT_W-1:0] - 1'b1;
            pulse_n_o <= 1'b0;
         end else if (!pulse_n_o) begin
            if (cnt_q == {CNT_W{1'b0}})
               pulse_n_o <= 1'b1;
            else
               cnt_q <= cnt_q - 1'b1;
         end
      end
   end

endmodule
`default_nettype wire

// >>> design/charge_temp_timer.v
// charge temperature qualification, safety timer and system target select
// assumes analog status inputs are synchronous to clk_sys_i
//
// Functional notes
// - start charging only inside cold-hot window
// - zero current outside window until return
// - warm voltage min(vreg,4.1V) unless keep-full
// - warm current scaled 0, 20, 50 or 100 percent
// - cool current 50 or 20 percent when enabled
// - cool voltage full, or min with 4.1V
// - cool zone without enable gives zero current
// - cool and warm boundaries each selectable
// - zone limiting can be switched off
// - boost leaves window: suspend, source status 000
// - boost fault code reported, cleared on return
// - timer expiry stops charge, fault 11, pulse
// - 2 hours below low battery, else 16
// - timer disable skips supervision
// - long limit becomes 7 hours when cleared
// - half rate in regulation or cool zone
// - half rate feature can be disabled
// - timer frozen during faults, then resumes
// - restart or enable toggle clears timer
// - floor from 3-bit field, active status bit
// - floor plus 180mV while battery below floor
// - battery plus 50mV when battery at or above floor
// - interrupt is one 256us low pulse
`timescale 1ns/1ps
`default_nettype none
`include "tq_regs.vh"

module charge_temp_timer #(
   parameter SENSE_W      = 10,
   parameter SEC_CYCLES   = `TQ_CLK_HZ,
   parameter PULSE_CYCLES = `TQ_INT_PULSE_US * `TQ_CLK_MHZ,
   parameter SHORT_SEC    = `TQ_SHORT_LIMIT_H * `TQ_SEC_PER_H,
   parameter LONG_SEC     = `TQ_LONG_LIMIT_H * `TQ_SEC_PER_H,
   parameter MID_SEC      = `TQ_MID_LIMIT_H * `TQ_SEC_PER_H
) (
   input  wire               clk_sys_i,
   input  wire               nrst_i,
   input  wire               ce_i,
   // register port
   input  wire [3:0]         reg_addr_i,
   input  wire [31:0]        reg_wdata_i,
   input  wire               reg_we_i,
   input  wire               reg_re_i,
   output reg  [31:0]        reg_rdata_o,
   // analog and pin status
   input  wire [SENSE_W-1:0] thermistor_sense_i,
   input  wire [15:0]        vbat_mv_i,
   input  wire               above_low_battery_level_i,
   input  wire               in_voltage_limit_active_i,
   input  wire               in_current_limit_active_i,
   input  wire               thermal_reg_active_i,
   input  wire               other_fault_i,
   input  wire               terminated_i,
   input  wire               restart_i,
   input  wire               charge_inhibit_n_i,
   input  wire               boost_request_i,
   input  wire [2:0]         input_type_i,
   // targets and status
   output reg  [11:0]        charge_current_o,
   output reg  [15:0]        charge_voltage_o,
   output reg  [15:0]        sys_target_o,
   output reg                charging_o,
   output reg                boost_run_o,
   output reg  [2:0]         input_source_status_o,
   output reg  [2:0]         thermistor_fault_code_o,
   output reg  [1:0]         charge_fault_code_o,
   output reg                sys_floor_active_o,
   output wire               host_event_n_o
);

   // percent selector codes for scale_cur
   localparam [1:0] PCT_0   = 2'h0;
   localparam [1:0] PCT_20  = 2'h1;
   localparam [1:0] PCT_50  = 2'h2;
   localparam [1:0] PCT_100 = 2'h3;

   localparam [26:0] SEC_LAST   = SEC_CYCLES[26:0] - 27'd1;
   localparam [15:0] SHORT_LIM  = SHORT_SEC[15:0];
   localparam [15:0] LONG_LIM   = LONG_SEC[15:0];
   localparam [15:0] MID_LIM    = MID_SEC[15:0];

   function [11:0] scale_cur;
      input [11:0] cur;
      input [1:0]  pct;
      reg   [21:0] prod;
      begin
         prod = cur * 10'd205;
         case (pct)
            PCT_0:   scale_cur = 12'h000;
            PCT_20:  scale_cur = prod[21:10];
            PCT_50:  scale_cur = {1'b0, cur[11:1]};
            default: scale_cur = cur;
         endcase
      end
   endfunction

   function [15:0] min_mv;
      input [15:0] a;
      input [15:0] b;
      begin
         min_mv = (a < b) ? a : b;
      end
   endfunction

   // software registers
   reg [`TQ_CTRL_WIDTH-1:0] ctrl_q;
   reg [15:0]               vreg_q;
   reg [11:0]               ichg_q;
   reg [SENSE_W-1:0]        boost_cold_q;
   reg [SENSE_W-1:0]        boost_hot_q;

   wire       charge_allow   = ctrl_q[`TQ_CTRL_CHARGE_ALLOW];
   wire       timer_en       = ctrl_q[`TQ_CTRL_TIMER_EN];
   wire       long_timer_sel = ctrl_q[`TQ_CTRL_LONG_TIMER];
   wire       slow_count_on  = ctrl_q[`TQ_CTRL_SLOW_COUNT];
   wire       zone_limit_en  = ctrl_q[`TQ_CTRL_ZONE_LIMIT];
   wire       warm_v_full    = ctrl_q[`TQ_CTRL_WARM_V_FULL];
   wire [1:0] warm_i_scale   = ctrl_q[`TQ_CTRL_WARM_I_LO +: 2];
   wire       cool_i_select  = ctrl_q[`TQ_CTRL_COOL_I_SEL];
   wire       cool_en        = ctrl_q[`TQ_CTRL_COOL_EN];
   wire       cool_v_lower   = ctrl_q[`TQ_CTRL_COOL_V_LOWER];
   wire [1:0] cool_t_sel     = ctrl_q[`TQ_CTRL_COOL_T_LO +: 2];
   wire [1:0] warm_t_sel     = ctrl_q[`TQ_CTRL_WARM_T_LO +: 2];
   wire [2:0] sys_floor_sel  = ctrl_q[`TQ_CTRL_SYS_FLOOR_LO +: 3];
   wire       boost_en       = ctrl_q[`TQ_CTRL_BOOST_EN];

   wire [2:0] zone;

   thermal_zone_classify #(
      .SENSE_W                 (SENSE_W)
   ) u_zone (
      .clk_sys_i               (clk_sys_i),
      .nrst_i                  (nrst_i),
      .ce_i                    (ce_i),
      .thermistor_sense_i      (thermistor_sense_i),
      .cool_threshold_select_i (cool_t_sel),
      .warm_threshold_select_i (warm_t_sel),
      .zone_o                  (zone)
   );

   wire in_window   = (zone != `TQ_ZONE_COLD) && (zone != `TQ_ZONE_HOT);
   wire charge_en   = charge_allow && !charge_inhibit_n_i;

   // state
   reg        charge_en_q;
   reg        timer_fault_q;
   reg        went_high_q;
   reg [26:0] sec_cnt_q;
   reg        half_q;
   reg [15:0] elapsed_q;
   reg [2:0]  zone_q;
   reg        boost_ok_q;

   wire enable_toggle = charge_en != charge_en_q;
   wire timer_clear   = restart_i || enable_toggle;
   wire zone_stop     = zone_limit_en && (!in_window ||
                        (zone == `TQ_ZONE_COOL && !cool_en));
   wire suspend       = zone_stop || other_fault_i;
   wire may_charge    = charge_en && !timer_fault_q && !terminated_i &&
                        (!zone_limit_en || in_window);
   wire slow_cond     = in_voltage_limit_active_i || in_current_limit_active_i ||
                        thermal_reg_active_i || (zone == `TQ_ZONE_COOL);
   wire sec_tick      = (sec_cnt_q == SEC_LAST);
   wire advance       = sec_tick && (!(slow_count_on && slow_cond) || half_q);
   wire [15:0] limit  = !went_high_q ? SHORT_LIM :
                        (long_timer_sel ? LONG_LIM : MID_LIM);
   wire timing        = timer_en && charging_o && !suspend;
   wire expire        = timing && advance && (elapsed_q + 16'h0001 >= limit);

   // timer
   always @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         charge_en_q   <= 1'b0;
         timer_fault_q <= 1'b0;
         went_high_q   <= 1'b0;
         sec_cnt_q     <= 27'h000_0000;
         half_q        <= 1'b0;
         elapsed_q     <= 16'h0000;
      end else if (ce_i) begin
         charge_en_q <= charge_en;
         if (timer_clear) begin
            timer_fault_q <= expire;
            went_high_q   <= 1'b0;
            sec_cnt_q     <= 27'h000_0000;
            half_q        <= 1'b0;
            elapsed_q     <= 16'h0000;
         end else if (timing) begin
            if (above_low_battery_level_i)
               went_high_q <= 1'b1;
            sec_cnt_q <= sec_tick ? 27'h000_0000 : sec_cnt_q + 27'h000_0001;
            if (sec_tick)
               half_q <= !half_q;
            if (expire)
               timer_fault_q <= 1'b1;
            else if (advance)
               elapsed_q <= elapsed_q + 16'h0001;
         end
      end
   end

   // targets
   reg [11:0] cur_d;
   reg [15:0] volt_d;
   reg [15:0] floor_mv;
   reg [15:0] sys_d;
   reg        boost_ok_d;
   reg [2:0]  ntc_d;

   always @* begin
      cur_d  = ichg_q;
      volt_d = vreg_q;
      if (zone_limit_en) begin
         case (zone)
            `TQ_ZONE_WARM: begin
               cur_d = scale_cur(ichg_q, warm_i_scale);
               if (!warm_v_full)
                  volt_d = min_mv(vreg_q, `TQ_WARM_COOL_VMAX);
            end
            `TQ_ZONE_COOL: begin
               if (!cool_en)
                  cur_d = 12'h000;
               else
                  cur_d = scale_cur(ichg_q, cool_i_select ? PCT_20 : PCT_50);
               if (cool_v_lower)
                  volt_d = min_mv(vreg_q, `TQ_WARM_COOL_VMAX);
            end
            `TQ_ZONE_COLD, `TQ_ZONE_HOT: begin
               cur_d = 12'h000;
            end
            default: begin
               cur_d = ichg_q;
            end
         endcase
      end
      if (!charging_o || suspend || timer_fault_q || expire)
         cur_d = 12'h000;
      floor_mv = `TQ_SYS_FLOOR_BASE + `TQ_SYS_FLOOR_STEP * {13'h0000, sys_floor_sel};
      if (vbat_mv_i < floor_mv)
         sys_d = floor_mv + `TQ_SYS_ABOVE_FLOOR;
      else
         sys_d = vbat_mv_i + `TQ_SYS_ABOVE_BAT;
      boost_ok_d = (thermistor_sense_i < boost_cold_q) && (thermistor_sense_i > boost_hot_q);
      ntc_d = `TQ_ZONE_NORMAL;
      if (boost_en && boost_request_i) begin
         if (thermistor_sense_i >= boost_cold_q)
            ntc_d = `TQ_ZONE_COLD;
         else if (thermistor_sense_i <= boost_hot_q)
            ntc_d = `TQ_ZONE_HOT;
      end else if (charging_o && zone_limit_en) begin
         ntc_d = zone;
      end
   end

   wire boost_active = boost_en && boost_request_i;
   wire event_trig   = expire || (zone != zone_q) ||
                       (boost_active && (boost_ok_d != boost_ok_q));

   always @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         charge_current_o        <= 12'h000;
         charge_voltage_o        <= `TQ_VREG_RESET;
         sys_target_o            <= `TQ_SYS_FLOOR_BASE;
         charging_o              <= 1'b0;
         boost_run_o             <= 1'b0;
         input_source_status_o   <= 3'h0;
         thermistor_fault_code_o <= 3'h0;
         charge_fault_code_o     <= 2'h0;
         sys_floor_active_o      <= 1'b0;
         zone_q                  <= `TQ_ZONE_NORMAL;
         boost_ok_q              <= 1'b0;
      end else if (ce_i) begin
         if (!charge_en || terminated_i || timer_fault_q || expire)
            charging_o <= 1'b0;
         else if (!charging_o && may_charge)
            charging_o <= 1'b1;
         charge_current_o      <= cur_d;
         charge_voltage_o      <= volt_d;
         sys_target_o          <= sys_d;
         sys_floor_active_o    <= vbat_mv_i < floor_mv;
         boost_run_o           <= boost_active && boost_ok_d;
         if (boost_active)
            input_source_status_o <= boost_ok_d ? `TQ_SRC_BOOST : 3'h0;
         else
            input_source_status_o <= input_type_i;
         thermistor_fault_code_o <= ntc_d;
         charge_fault_code_o     <= (timer_fault_q || expire) ?
                                    `TQ_CHG_FAULT_TIMER : 2'h0;
         zone_q     <= zone;
         boost_ok_q <= boost_ok_d;
      end
   end

   event_pulse_gen #(
      .PULSE_CYCLES (PULSE_CYCLES),
      .CNT_W        (32)
   ) u_pulse (
      .clk_sys_i    (clk_sys_i),
      .nrst_i       (nrst_i),
      .ce_i         (ce_i),
      .trig_i       (event_trig),
      .pulse_n_o    (host_event_n_o)
   );

   // register port
   always @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ctrl_q       <= `TQ_CTRL_RESET;
         vreg_q       <= `TQ_VREG_RESET;
         ichg_q       <= `TQ_ICHG_RESET;
         boost_cold_q <= `TQ_BOOST_COLD_RESET;
         boost_hot_q  <= `TQ_BOOST_HOT_RESET;
         reg_rdata_o  <= 32'h0000_0000;
      end else if (ce_i) begin
         if (reg_we_i) begin
            case (reg_addr_i)
               `TQ_REG_CTRL:      ctrl_q <= reg_wdata_i[`TQ_CTRL_WIDTH-1:0];
               `TQ_REG_VREG:      vreg_q <= reg_wdata_i[15:0];
               `TQ_REG_ICHG:      ichg_q <= reg_wdata_i[11:0];
               `TQ_REG_BOOST_WIN: begin
                  boost_cold_q <= reg_wdata_i[SENSE_W-1:0];
                  boost_hot_q  <= reg_wdata_i[16 +: SENSE_W];
               end
               default: begin
                  ctrl_q <= ctrl_q;
               end
            endcase
         end
         reg_rdata_o <= 32'h0000_0000;
         if (reg_re_i) begin
            case (reg_addr_i)
               `TQ_REG_CTRL:      reg_rdata_o <= {{(32-`TQ_CTRL_WIDTH){1'b0}}, ctrl_q};
               `TQ_REG_VREG:      reg_rdata_o <= {16'h0000, vreg_q};
               `TQ_REG_ICHG:      reg_rdata_o <= {20'h0_0000, ichg_q};
               `TQ_REG_BOOST_WIN: reg_rdata_o <= {{(16-SENSE_W){1'b0}}, boost_hot_q,
                                                  {(16-SENSE_W){1'b0}}, boost_cold_q};
               `TQ_REG_STATUS:    reg_rdata_o <= {18'h0_0000, timer_fault_q, zone,
                                                  charging_o, sys_floor_active_o,
                                                  input_source_status_o,
                                                  thermistor_fault_code_o,
                                                  charge_fault_code_o};
               `TQ_REG_TIMER:     reg_rdata_o <= {16'h0000, elapsed_q};
               default:           reg_rdata_o <= 32'h0000_0000;
            endcase
         end
      end
   end

endmodule
`default_nettype wire

// >>> verif/tq_checker_assertions.sv
// port-level assertions for the charge temperature and timer block
// assumes PULSE_CYCLES of 8 and sys floor select 7 once vbat drops
`timescale 1ns/1ps
`default_nettype none
module tq_checker (
   input wire logic        clk_sys_i,
   input wire logic        nrst_i,
   input wire logic        reg_re_i,
   input wire logic [31:0] reg_rdata_o,
   input wire logic [9:0]  thermistor_sense_i,
   input wire logic [15:0] vbat_mv_i,
   input wire logic        terminated_i,
   input wire logic        boost_request_i,
   input wire logic [11:0] charge_current_o,
   input wire logic        charging_o,
   input wire logic [15:0] sys_target_o,
   input wire logic        sys_floor_active_o,
   input wire logic [2:0]  input_source_status_o,
   input wire logic [2:0]  thermistor_fault_code_o,
   input wire logic [1:0]  charge_fault_code_o,
   input wire logic        host_event_n_o
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!nrst_i);
   pulse_width_a: assert property (
      $fell(host_event_n_o) |-> !host_event_n_o [*8] ##1 host_event_n_o)
      else $error("event pulse width wrong");
   fault_pulse_a: assert property (
      $rose(charge_fault_code_o == 2'h3) |-> ##[0:2] !host_event_n_o)
      else $error("no pulse on timer expiry");
   fault_stop_a: assert property (
      charge_fault_code_o == 2'h3 && $past(charge_fault_code_o) == 2'h3
      |-> !charging_o && charge_current_o == 12'h000)
      else $error("charging after timer expiry");
   window_zero_a: assert property (
      (!boost_request_i && (thermistor_sense_i <= 10'h12C || thermistor_sense_i >= 10'h2E4))
      [*3] |-> charge_current_o == 12'h000)
      else $error("current outside window");
   cold_code_a: assert property (
      (!boost_request_i && thermistor_sense_i >= 10'h2E4) [*3]
      |-> thermistor_fault_code_o == 3'h5)
      else $error("cold zone not reported");
   floor_target_a: assert property (
      (vbat_mv_i < 16'h0DAC) [*2] |-> sys_target_o == 16'h0E60 && sys_floor_active_o)
      else $error("floor target wrong");
   bat_target_a: assert property (
      (vbat_mv_i > 16'h0DAC && terminated_i && $stable(vbat_mv_i)) [*2]
      |-> sys_target_o == vbat_mv_i + 16'h0032)
      else $error("battery target wrong");
   boost_stop_a: assert property (
      (boost_request_i && thermistor_sense_i >= 10'h300) [*3]
      |-> input_source_status_o == 3'h0 && thermistor_fault_code_o != 3'h0)
      else $error("boost not suspended");
   rdata_idle_a: assert property (
      !$past(reg_re_i) |-> reg_rdata_o == 32'h0000_0000)
      else $error("read data outside slot");
endmodule
`default_nettype wire

// >>> verif/host_irq_model.sv
// host side: measures each low pulse on the event line
// assumes the line is driven by a flop on clk_sys_i
`timescale 1ns/1ps
`default_nettype none
module host_irq_model (
   input  wire logic clk_sys_i,
   input  wire logic host_event_n_i,
   output var  int   pulse_width_o,
   output var  int   pulse_count_o
);
   int run_q;
   always @(posedge clk_sys_i) begin
      if (!host_event_n_i) begin
         run_q <= run_q + 1;
      end else if (run_q != 0) begin
         pulse_width_o <= run_q;
         pulse_count_o <= pulse_count_o + 1;
         run_q <= 0;
      end
   end
endmodule
`default_nettype wire

// >>> verif/tb_charge_temp_timer.sv
// self-checking bench for charge_temp_timer
// assumes shortened counts: 4 cycles a second, 8 cycle pulses
`timescale 1ns/1ps
`default_nettype none
`include "tq_regs.vh"
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin error_cnt++; \
   $display("[ERR] %0t got %h want %h", $time, (a), (e)); end end
module tb_charge_temp_timer;
   localparam logic [31:0] BASE = 32'h0003_829F;
   logic        clk_sys_i = 1'b0;
   logic        nrst_i = 1'b0;
   logic [3:0]  reg_addr_i = 4'h0;
   logic [31:0] reg_wdata_i = 32'h0000_0000;
   logic        reg_we_i = 1'b0;
   logic        reg_re_i = 1'b0;
   logic [9:0]  thermistor_sense_i = 10'h200;
   logic [15:0] vbat_mv_i = 16'h0E10;
   logic        above_low_battery_level_i = 1'b0;
   logic        ce_i = 1'b1;
   // other fault, vin limit, iin limit, thermal
   logic [3:0]  cond = 4'h0;
   logic [2:0]  input_type_i = 3'h2;
   logic        terminated_i = 1'b0;
   logic        restart_i = 1'b1;
   logic        charge_inhibit_n_i = 1'b0;
   logic        boost_request_i = 1'b0;
   wire  [31:0] reg_rdata_o;
   wire  [11:0] charge_current_o;
   wire  [15:0] charge_voltage_o;
   wire  [15:0] sys_target_o;
   wire         charging_o;
   wire         boost_run_o;
   wire  [2:0]  input_source_status_o;
   wire  [2:0]  thermistor_fault_code_o;
   wire  [1:0]  charge_fault_code_o;
   wire         sys_floor_active_o;
   wire         host_event_n_o;
   int          pulse_width;
   int          error_cnt = 0;
   int          comparisons = 0;

   always #5 clk_sys_i = ~clk_sys_i;

   charge_temp_timer #(.SEC_CYCLES(4), .PULSE_CYCLES(8), .SHORT_SEC(3), .LONG_SEC(8),
      .MID_SEC(5)) DUT (.clk_sys_i, .nrst_i, .ce_i, .reg_addr_i, .reg_wdata_i, .reg_we_i,
      .reg_re_i, .reg_rdata_o, .thermistor_sense_i, .vbat_mv_i, .above_low_battery_level_i,
      .in_voltage_limit_active_i(cond[2]), .in_current_limit_active_i(cond[1]),
      .thermal_reg_active_i(cond[0]), .other_fault_i(cond[3]), .terminated_i, .restart_i,
      .charge_inhibit_n_i, .boost_request_i, .input_type_i, .charge_current_o,
      .charge_voltage_o, .sys_target_o, .charging_o,
      .boost_run_o, .input_source_status_o, .thermistor_fault_code_o, .charge_fault_code_o,
      .sys_floor_active_o, .host_event_n_o);

   host_irq_model u_host (.clk_sys_i, .host_event_n_i(host_event_n_o),
      .pulse_width_o(pulse_width), .pulse_count_o());

   task automatic wt();
      repeat (5) @(posedge clk_sys_i);
      #1;
   endtask

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_sys_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_we_i <= 1'b1;
      @(posedge clk_sys_i);
      reg_we_i <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      @(posedge clk_sys_i);
      reg_addr_i <= a;
      reg_re_i <= 1'b1;
      @(posedge clk_sys_i);
      reg_re_i <= 1'b0;
      #1;
      `CHK(reg_rdata_o, e)
   endtask

   // zero voltage argument skips the voltage compare
   task automatic zt(input logic [31:0] c, input logic [9:0] s, input logic [11:0] i,
                     input logic [15:0] v);
      wr(`TQ_REG_CTRL, c);
      thermistor_sense_i <= s;
      wt();
      `CHK(charge_current_o, i)
      if (v != 16'h0000) `CHK(charge_voltage_o, v)
   endtask

   // clears the timer, then counts cycles up to expiry
   task automatic tmr(input logic [31:0] c, input logic a, input logic [3:0] h, input int lo,
                      input int hi);
      int n;
      n = 0;
      wr(`TQ_REG_CTRL, c);
      above_low_battery_level_i <= a;
      cond <= h;
      restart_i <= 1'b1;
      @(posedge clk_sys_i);
      restart_i <= 1'b0;
      charge_inhibit_n_i <= 1'b1;
      @(posedge clk_sys_i);
      charge_inhibit_n_i <= 1'b0;
      #1;
      while (charge_fault_code_o !== 2'h3 && n < 200) begin
         @(posedge clk_sys_i);
         #1 n++;
      end
      `CHK(n >= lo && n <= hi, 1'b1)
   endtask

   task automatic results();
      $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   initial begin
      #200000;
      error_cnt++;
      results();
   end

   initial begin
      repeat (8) @(posedge clk_sys_i);
      nrst_i <= 1'b1;
      rd(`TQ_REG_CTRL, {13'h0, `TQ_CTRL_RESET});
      rd(`TQ_REG_VREG, {16'h0, `TQ_VREG_RESET});
      rd(`TQ_REG_ICHG, {20'h0, `TQ_ICHG_RESET});
      rd(`TQ_REG_BOOST_WIN, {6'h0, `TQ_BOOST_HOT_RESET, 6'h0, `TQ_BOOST_COLD_RESET});
      rd(4'hF, 32'h0000_0000);
      ce_i <= 1'b0;
      wr(`TQ_REG_VREG, 32'h0000_0FA0);
      ce_i <= 1'b1;
      rd(`TQ_REG_VREG, {16'h0, `TQ_VREG_RESET});
      $display("test registers done");
      zt(BASE, 10'h200, 12'h7BC, 16'h1070);
      zt(BASE & ~32'hC0, 10'h150, 12'h000, 16'h1004);
      zt(BASE & ~32'hC0 | 32'h40, 10'h150, 12'h18C, 16'h1004);
      zt(BASE, 10'h150, 12'h3DE, 16'h1004);
      zt(BASE | 32'h20, 10'h150, 12'h3DE, 16'h1070);
      zt(BASE, 10'h2B0, 12'h3DE, 16'h1070);
      zt(BASE | 32'h100, 10'h2B0, 12'h18C, 16'h1070);
      zt(BASE | 32'h400, 10'h2B0, 12'h3DE, 16'h1004);
      zt(BASE & ~32'h200, 10'h2B0, 12'h000, 16'h0000);
      zt(BASE | 32'h1800, 10'h270, 12'h3DE, 16'h0000);
      zt(BASE | 32'h6000, 10'h1A0, 12'h7BC, 16'h0000);
      zt(BASE & ~32'h10, 10'h150, 12'h7BC, 16'h1070);
      zt(BASE, 10'h2F0, 12'h000, 16'h0000);
      zt(BASE, 10'h100, 12'h000, 16'h0000);
      zt(BASE, 10'h200, 12'h7BC, 16'h1070);
      $display("test zones done");
      tmr(BASE, 1'b0, 4'h0, 8, 20);
      repeat (12) @(posedge clk_sys_i);
      `CHK(pulse_width, 8)
      tmr(BASE, 1'b0, 4'h2, 20, 32);
      tmr(BASE, 1'b0, 4'h4, 20, 32);
      tmr(BASE, 1'b0, 4'h1, 20, 32);
      tmr(BASE & ~32'h8, 1'b0, 4'h7, 8, 20);
      tmr(BASE, 1'b1, 4'h0, 28, 40);
      tmr(BASE & ~32'h4, 1'b1, 4'h0, 16, 28);
      tmr(BASE, 1'b0, 4'h8, 200, 200);
      tmr(BASE & ~32'h2, 1'b0, 4'h0, 200, 200);
      $display("test timer done");
      wr(`TQ_REG_CTRL, BASE | 32'h0004_0000);
      boost_request_i <= 1'b1;
      wt();
      `CHK(input_source_status_o, 3'h7)
      thermistor_sense_i <= 10'h300;
      wt();
      `CHK(input_source_status_o, 3'h0)
      `CHK(thermistor_fault_code_o != 3'h0, 1'b1)
      thermistor_sense_i <= 10'h200;
      wt();
      `CHK(thermistor_fault_code_o, 3'h0)
      boost_request_i <= 1'b0;
      $display("test boost done");
      vbat_mv_i <= 16'h0CE4;
      wt();
      `CHK(sys_target_o, 16'h0E60)
      rd(`TQ_REG_STATUS, 32'h0000_2143);
      vbat_mv_i <= 16'h0ED8;
      terminated_i <= 1'b1;
      wt();
      `CHK(sys_target_o, 16'h0F0A)
      $display("test system target done");
      results();
   end
endmodule

bind charge_temp_timer tq_checker u_chk (.clk_sys_i, .nrst_i, .reg_re_i, .reg_rdata_o,
   .thermistor_sense_i, .vbat_mv_i, .terminated_i, .boost_request_i, .charge_current_o,
   .charging_o, .sys_target_o, .sys_floor_active_o, .input_source_status_o,
   .thermistor_fault_code_o, .charge_fault_code_o, .host_event_n_o);
`default_nettype wire
